/* hdl/cses_bus_if.sv */
interface cses_bus_if;
    logic req;
    logic write;
    logic [31:0] addr;
    cses_pkg::cses_size_t size;
    logic is_signed;
    logic is_fetch;
    logic nonsecure;
    logic [63:0] wdata;
    logic [7:0] lane_en;
    logic [63:0] rdata;
    logic rvalid;
    logic write_lock;
    modport core (output req, write, addr, size, is_signed, is_fetch, nonsecure,
        wdata, lane_en, input rdata, rvalid, write_lock);
    modport system (input req, write, addr, size, is_signed, is_fetch, nonsecure,
        wdata, lane_en, output rdata, rvalid, write_lock);
endinterface

/* hdl/cses_core.sv */
// Behaviour
// - state bits select one of four sets
// - status writes leave state bits, except debug
// - wide/compact switch keeps mode and registers
// - state changes only by named ops
// - exceptions run only in wide/compact
// - exception return copies saved into current
// - byte to doubleword, signed or unsigned
// - doubleword/multiple transfers need word alignment
// - memory is linear ascending byte array
// - little and byte-invariant big endian only
// - instruction fetches always little endian
// - byte n on lane n, both endians
// - halfword lane order swaps in big endian
// - word lanes by offset, bytes reversed big
// - modified virtual equals virtual address
// - nonsecure core: nonsecure bases, all nonsecure
// - secure core: descriptor flag gives security
// - miss access nonsecure if core nonsecure
// - second-level fetch secure in secure state
// - data physical, instruction virtual index; data index here is op_data_i with bit 0 cleared
// - reset: supervisor, secure, flag zero
// - lock input faults protected writes only
// - chip holds lock low at reset
module cses_core (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    cses_bus_if.core bus,
    input wire cses_pkg::cses_op_t op_i,
    input wire logic op_valid_i,
    input wire logic [31:0] op_data_i,
    input wire logic debug_mode_i,
    input wire logic big_endian_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_fetch_i,
    input wire logic req_multi_i,
    input wire logic req_signed_i,
    input wire cses_pkg::cses_size_t req_size_i,
    input wire logic [31:0] req_vaddr_i,
    input wire logic [63:0] req_wdata_i,
    input wire logic desc_nonsecure_i,
    input wire logic desc_second_level_i,
    input wire logic [31:0] saved_status_word_i,
    input wire logic nonsecure_flag_wr_i,
    input wire logic nonsecure_flag_val_i,
    input wire logic protected_write_i,
    output logic [31:0] current_status_word_o,
    output logic [1:0] isa_state_o,
    output logic nonsecure_flag_o,
    output logic table_base_nonsecure_o,
    output logic [31:0] mod_vaddr_o,
    output logic [31:0] dcache_index_o,
    output logic [31:0] icache_index_o,
    output logic undef_exc_o,
    output logic align_fault_o,
    output logic [63:0] load_data_o,
    output logic load_valid_o
);
    import cses_pkg::*;
    // ---------------------------------------------------------------
    // status word and state decode
    // ---------------------------------------------------------------
    logic [31:0] current_status_word;
    logic nonsecure_flag;
    logic [CSES_SYNC_STAGES-1:0] lock_sync;
    logic lock_now;
    // a change counts only once the last two stages agree
    wire logic lock_settled = lock_sync[2] == lock_sync[1];
    wire logic [1:0] isa_state = {current_status_word[CSES_SW_BYTECODE_POS],
        current_status_word[CSES_SW_COMPACT_POS]};
    wire logic in_wc = ~isa_state[1];
    wire logic [31:0] op_target = {op_data_i[31:1], 1'b0};
    logic [31:0] next_sw;
    always_comb begin
        next_sw = current_status_word;
        if (op_valid_i) begin
            unique case (op_i)
                // only the compact bit moves, mode and registers untouched
                CSES_OP_BRANCH_EXCHANGE, CSES_OP_BRANCH_LINK_EXCHANGE,
                CSES_OP_LOAD_PC: begin
                    if (in_wc) begin
                        next_sw[CSES_SW_COMPACT_POS] = op_data_i[0];
                    end
                end
                CSES_OP_MANAGED_ENTER: begin
                    if (isa_state == CSES_ISA_COMPACT) begin
                        next_sw[CSES_SW_BYTECODE_POS] = 1'b1;
                    end
                end
                CSES_OP_MANAGED_LEAVE: begin
                    if (isa_state == CSES_ISA_MANAGED) begin
                        next_sw[CSES_SW_BYTECODE_POS] = 1'b0;
                    end
                end
                CSES_OP_BYTECODE_BRANCH: begin
                    if (in_wc) begin
                        next_sw[CSES_SW_BYTECODE_POS] = 1'b1;
                        next_sw[CSES_SW_COMPACT_POS] = 1'b0;
                    end
                end
                CSES_OP_STATUS_WRITE: begin
                    next_sw = op_data_i;
                    if (!debug_mode_i) begin
                        next_sw[CSES_SW_BYTECODE_POS] =
                            current_status_word[CSES_SW_BYTECODE_POS];
                        next_sw[CSES_SW_COMPACT_POS] =
                            current_status_word[CSES_SW_COMPACT_POS];
                    end
                end
                CSES_OP_EXC_ENTRY: begin
                    next_sw = op_data_i;
                    next_sw[CSES_SW_BYTECODE_POS] = 1'b0;
                end
                CSES_OP_EXC_RETURN: begin
                    next_sw = saved_status_word_i;
                end
                default: begin
                    next_sw = current_status_word;
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            current_status_word <= CSES_SW_RESET;
            nonsecure_flag <= CSES_NS_RESET;
            lock_sync <= '0;
            lock_now <= 1'b0;
        end else begin
            current_status_word <= next_sw;
            // only in secure-side code may the flag move
            if (nonsecure_flag_wr_i && !nonsecure_flag) begin
                nonsecure_flag <= nonsecure_flag_val_i;
            end
            lock_sync <= {lock_sync[1:0], bus.write_lock};
            if (lock_settled) begin
                lock_now <= lock_sync[1];
            end
        end
    end
    // ---------------------------------------------------------------
    // address and security attributes
    // ---------------------------------------------------------------
    wire logic [31:0] mva = req_vaddr_i;
    // second-level fetch stays secure in secure state
    wire logic access_ns = nonsecure_flag |
        (desc_nonsecure_i & ~desc_second_level_i);
    wire logic misaligned = (req_size_i == CSES_SZ_HALF && req_vaddr_i[0]) ||
        ((req_size_i == CSES_SZ_WORD || req_size_i == CSES_SZ_DOUBLE || req_multi_i)
        && req_vaddr_i[1:0] != 2'h0);
    // ---------------------------------------------------------------
    // byte-lane steering, 64-bit bus
    // ---------------------------------------------------------------
    wire logic be_data = big_endian_i & ~req_fetch_i;
    wire logic [2:0] off = req_vaddr_i[2:0];
    logic [63:0] lane_wdata;
    logic [7:0] lane_en;
    always_comb begin
        lane_wdata = '0;
        lane_en = '0;
        unique case (req_size_i)
            CSES_SZ_BYTE: begin
                lane_wdata = {56'h0, req_wdata_i[7:0]} << {off, 3'h0};
                lane_en = 8'h01 << off;
            end
            CSES_SZ_HALF: begin
                lane_wdata = {48'h0, be_data ? {req_wdata_i[7:0], req_wdata_i[15:8]}
                    : req_wdata_i[15:0]} << {off[2:1], 4'h0};
                lane_en = 8'h03 << {off[2:1], 1'b0};
            end
            CSES_SZ_WORD: begin
                lane_wdata = {32'h0, be_data ? {req_wdata_i[7:0], req_wdata_i[15:8],
                    req_wdata_i[23:16], req_wdata_i[31:24]} : req_wdata_i[31:0]}
                    << {off[2], 5'h0};
                lane_en = off[2] ? 8'hf0 : 8'h0f;
            end
            CSES_SZ_DOUBLE: begin
                lane_wdata = req_wdata_i;
                lane_en = 8'hff;
            end
        endcase
    end
    // load: undo steering, then extend
    cses_size_t ld_size;
    logic [2:0] ld_off;
    logic ld_be;
    logic ld_signed;
    logic [63:0] ld_val;
    always_comb begin
        ld_val = bus.rdata;
        unique case (ld_size)
            CSES_SZ_BYTE: begin
                ld_val = bus.rdata >> {ld_off, 3'h0};
                ld_val = {{56{ld_signed & ld_val[7]}}, ld_val[7:0]};
            end
            CSES_SZ_HALF: begin
                ld_val = bus.rdata >> {ld_off[2:1], 4'h0};
                if (ld_be) begin
                    ld_val[15:0] = {ld_val[7:0], ld_val[15:8]};
                end
                ld_val = {{48{ld_signed & ld_val[15]}}, ld_val[15:0]};
            end
            CSES_SZ_WORD: begin
                ld_val = bus.rdata >> {ld_off[2], 5'h0};
                if (ld_be) begin
                    ld_val[31:0] = {ld_val[7:0], ld_val[15:8], ld_val[23:16],
                        ld_val[31:24]};
                end
                ld_val = {{32{ld_signed & ld_val[31]}}, ld_val[31:0]};
            end
            CSES_SZ_DOUBLE: begin
                ld_val = bus.rdata;
            end
        endcase
    end
    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    wire logic issue = req_i & ~misaligned;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus.req <= 1'b0;
            bus.write <= 1'b0;
            bus.addr <= '0;
            bus.size <= CSES_SZ_BYTE;
            bus.is_signed <= 1'b0;
            bus.is_fetch <= 1'b0;
            bus.nonsecure <= 1'b0;
            bus.wdata <= '0;
            bus.lane_en <= '0;
            ld_size <= CSES_SZ_BYTE;
            ld_off <= '0;
            ld_be <= 1'b0;
            ld_signed <= 1'b0;
            load_data_o <= '0;
            load_valid_o <= 1'b0;
            align_fault_o <= 1'b0;
            undef_exc_o <= 1'b0;
            mod_vaddr_o <= '0;
            dcache_index_o <= '0;
            icache_index_o <= '0;
            table_base_nonsecure_o <= 1'b0;
        end else begin
            bus.req <= issue;
            bus.write <= req_write_i;
            bus.addr <= mva;
            bus.size <= req_size_i;
            bus.is_signed <= req_signed_i;
            bus.is_fetch <= req_fetch_i;
            bus.nonsecure <= access_ns;
            bus.wdata <= lane_wdata;
            bus.lane_en <= lane_en;
            if (issue && !req_write_i) begin
                ld_size <= req_size_i;
                ld_off <= off;
                ld_be <= be_data;
                ld_signed <= req_signed_i;
            end
            load_data_o <= ld_val;
            load_valid_o <= bus.rvalid;
            align_fault_o <= req_i & misaligned;
            undef_exc_o <= protected_write_i & lock_now;
            mod_vaddr_o <= mva;
            // data index is op_data_i with bit 0 cleared, virtual index straight
            dcache_index_o <= op_target;
            icache_index_o <= mva;
            table_base_nonsecure_o <= nonsecure_flag;
        end
    end
    assign current_status_word_o = current_status_word;
    assign isa_state_o = isa_state;
    assign nonsecure_flag_o = nonsecure_flag;
endmodule

/* hdl/cses_pkg.sv */
package cses_pkg;
    // ---------------------------------------------------------------
    // instruction-set states, first bit is the bytecode bit
    // ---------------------------------------------------------------
    localparam logic [1:0] CSES_ISA_WIDE = 2'h0;
    localparam logic [1:0] CSES_ISA_COMPACT = 2'h1;
    localparam logic [1:0] CSES_ISA_BYTECODE = 2'h2;
    localparam logic [1:0] CSES_ISA_MANAGED = 2'h3;
    // ---------------------------------------------------------------
    // status word layout and reset value
    // ---------------------------------------------------------------
    localparam int CSES_SW_BYTECODE_POS = 24;
    localparam int CSES_SW_COMPACT_POS = 5;
    localparam int CSES_SW_MODE_LSB = 0;
    localparam logic [4:0] CSES_MODE_SUPERVISOR = 5'h13;
    localparam logic [31:0] CSES_SW_RESET = 32'h000001d3;
    localparam logic CSES_NS_RESET = 1'h0;
    // ---------------------------------------------------------------
    // access sizes and state-change operations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CSES_SZ_BYTE = 2'h0,
        CSES_SZ_HALF = 2'h1,
        CSES_SZ_WORD = 2'h2,
        CSES_SZ_DOUBLE = 2'h3
    } cses_size_t;
    typedef enum logic [3:0] {
        CSES_OP_NONE = 4'h0,
        CSES_OP_BRANCH_EXCHANGE = 4'h1,
        CSES_OP_BRANCH_LINK_EXCHANGE = 4'h2,
        CSES_OP_LOAD_PC = 4'h3,
        CSES_OP_MANAGED_ENTER = 4'h4,
        CSES_OP_MANAGED_LEAVE = 4'h5,
        CSES_OP_BYTECODE_BRANCH = 4'h6,
        CSES_OP_STATUS_WRITE = 4'h7,
        CSES_OP_EXC_ENTRY = 4'h8,
        CSES_OP_EXC_RETURN = 4'h9
    } cses_op_t;
    localparam int CSES_SYNC_STAGES = 3;
endpackage

/* hdl/cses_system.sv */
module cses_system (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    cses_bus_if.system bus,
    input wire logic lock_request_i,
    input wire logic [63:0] mem_rdata_i,
    output logic mem_req_o,
    output logic mem_write_o,
    output logic [31:0] mem_addr_o,
    output logic [63:0] mem_wdata_o,
    output logic [7:0] mem_lane_en_o,
    output logic mem_nonsecure_o
);
    import cses_pkg::*;
    logic lock;
    logic rvalid;
    logic [63:0] rdata;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            mem_req_o <= 1'b0;
            mem_write_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= '0;
            mem_lane_en_o <= '0;
            mem_nonsecure_o <= 1'b0;
        end else begin
            lock <= lock_request_i;
            rvalid <= bus.req & ~bus.write;
            rdata <= mem_rdata_i;
            mem_req_o <= bus.req;
            mem_write_o <= bus.write;
            mem_addr_o <= {bus.addr[31:3], 3'h0};
            mem_wdata_o <= bus.wdata;
            mem_lane_en_o <= bus.lane_en;
            mem_nonsecure_o <= bus.nonsecure;
        end
    end
    assign bus.write_lock = lock;
    assign bus.rvalid = rvalid;
    assign bus.rdata = rdata;
endmodule

/* tb/core_state_endian_security_tb_top.sv */
module core_state_endian_security_tb_top
    import cses_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_i, reset_n_i, op_valid_i, debug_mode_i, big_endian_i, req_i, req_write_i;
    logic req_fetch_i, req_multi_i, req_signed_i, desc_nonsecure_i, desc_second_level_i;
    logic nonsecure_flag_wr_i, nonsecure_flag_val_i, protected_write_i, lock_request_i;
    logic nonsecure_flag_o, table_base_nonsecure_o, undef_exc_o, align_fault_o, load_valid_o;
    logic mem_req_o, mem_write_o, mem_nonsecure_o, nsf;
    cses_op_t op_i;
    cses_size_t req_size_i;
    logic [31:0] op_data_i, req_vaddr_i, saved_status_word_i, current_status_word_o;
    logic [31:0] mod_vaddr_o, mem_addr_o, dcache_index_o, icache_index_o;
    logic [31:0] lfsr = 32'hd1da8608;
    logic [63:0] req_wdata_i, mem_rdata_i, load_data_o, mem_wdata_o;
    logic [1:0] isa_state_o, st;
    logic [7:0] mem_lane_en_o;
    int failures, total_checks;
    cses_bus_if bus_c();
    cses_core cses_core_i (.sys_clk_i, .reset_n_i, .bus(bus_c), .op_i, .op_valid_i, .op_data_i,
        .debug_mode_i, .big_endian_i, .req_i, .req_write_i, .req_fetch_i, .req_multi_i,
        .req_signed_i, .req_size_i, .req_vaddr_i, .req_wdata_i, .desc_nonsecure_i,
        .desc_second_level_i, .saved_status_word_i, .nonsecure_flag_wr_i, .nonsecure_flag_val_i,
        .protected_write_i, .current_status_word_o, .isa_state_o, .nonsecure_flag_o,
        .table_base_nonsecure_o, .mod_vaddr_o, .dcache_index_o, .icache_index_o,
        .undef_exc_o, .align_fault_o, .load_data_o, .load_valid_o);
    cses_system cses_system_i (.sys_clk_i, .reset_n_i, .bus(bus_c), .lock_request_i,
        .mem_rdata_i, .mem_req_o, .mem_write_o, .mem_addr_o, .mem_wdata_o, .mem_lane_en_o,
        .mem_nonsecure_o);
    cses_assertions cses_assertions_i (.sys_clk_i, .reset_n_i, .req(bus_c.req),
        .write(bus_c.write), .addr(bus_c.addr), .size(bus_c.size), .lane_en(bus_c.lane_en),
        .rvalid(bus_c.rvalid), .write_lock(bus_c.write_lock));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic do_op(input cses_op_t op, input logic [31:0] d, input logic dbg);
        @(posedge sys_clk_i);
        {op_valid_i, debug_mode_i} <= {1'b1, dbg};
        op_i <= op;
        op_data_i <= d;
        saved_status_word_i <= d;
        case (op)
            CSES_OP_BRANCH_EXCHANGE, CSES_OP_BRANCH_LINK_EXCHANGE, CSES_OP_LOAD_PC:
                st = st[1] ? st : {1'b0, d[0]};
            CSES_OP_MANAGED_ENTER: st = st == CSES_ISA_COMPACT ? CSES_ISA_MANAGED : st;
            CSES_OP_MANAGED_LEAVE: st = st == CSES_ISA_MANAGED ? CSES_ISA_COMPACT : st;
            CSES_OP_BYTECODE_BRANCH: st = st[1] ? st : CSES_ISA_BYTECODE;
            CSES_OP_STATUS_WRITE: st = dbg ? {d[CSES_SW_BYTECODE_POS], d[CSES_SW_COMPACT_POS]} : st;
            CSES_OP_EXC_ENTRY: st = {1'b0, d[CSES_SW_COMPACT_POS]};
            CSES_OP_EXC_RETURN: st = {d[CSES_SW_BYTECODE_POS], d[CSES_SW_COMPACT_POS]};
            default: st = st;
        endcase
        @(posedge sys_clk_i);
        op_valid_i <= 1'b0;
        #1;
        if (op == CSES_OP_EXC_ENTRY)
            chk(isa_state_o[1], 1'b0);
        chk(isa_state_o, st);
        chk(dcache_index_o, {d[31:1], 1'b0});
        if (op == CSES_OP_EXC_RETURN)
            chk(current_status_word_o, d);
        else if (op < CSES_OP_MANAGED_ENTER)
            chk(current_status_word_o[4:0], CSES_MODE_SUPERVISOR);
    endtask
    task automatic access(input logic wr, input cses_size_t sz, input logic [2:0] off);
        logic [63:0] d, rd, e, m, r;
        logic [31:0] a, v;
        logic [7:0] ln;
        logic be, fe, ns, bad, mu;
        int n, k, p;
        n = 1 << sz;
        a = rnd();
        a[2:0] = off;
        d = {rnd(), rnd()};
        rd = {rnd(), rnd()};
        v = rnd();
        be = v[0];
        fe = !wr && sz == CSES_SZ_WORD && v[2];
        mu = v[5];
        ns = nsf | (v[3] & !v[4]);
        // multiple-register transfers are word sized, so need word alignment
        bad = ((sz[1] || mu) && off[1:0] != 2'h0) || (sz == CSES_SZ_HALF && off[0]);
        // a doubleword fills the whole bus, unswapped
        p = (n == 8) ? 0 : off;
        {e, m, r, ln} = '0;
        // fetches ignore the data endian setting
        for (int i = 0; i < n && !bad; i++) begin
            k = (be && !fe && n < 8) ? n - 1 - i : i;
            ln[p + i] = 1'b1;
            m[8 * (p + i) +: 8] = 8'hff;
            e[8 * (p + i) +: 8] = d[8 * k +: 8];
            r[8 * k +: 8] = rd[8 * (p + i) +: 8];
        end
        if (v[1] && n < 8 && r[8 * n - 1])
            r = r | ~((64'h1 << (8 * n)) - 64'h1);
        @(posedge sys_clk_i);
        {req_i, req_write_i, req_fetch_i, req_signed_i, big_endian_i} <= {1'b1, wr, fe, v[1], be};
        req_multi_i <= mu;
        {desc_nonsecure_i, desc_second_level_i} <= {v[3], v[4]};
        req_size_i <= sz;
        req_vaddr_i <= a;
        req_wdata_i <= d;
        mem_rdata_i <= rd;
        @(posedge sys_clk_i);
        req_i <= 1'b0;
        #1;
        chk(align_fault_o, bad);
        chk(mod_vaddr_o, a);
        chk(icache_index_o, a);
        repeat (3) if (mem_req_o !== 1'b1) begin
            @(posedge sys_clk_i);
            #1;
        end
        chk(mem_req_o, !bad);
        if (bad)
            return;
        chk({mem_write_o, mem_nonsecure_o, mem_lane_en_o}, {wr, ns, ln});
        chk(mem_addr_o, {a[31:3], 3'h0});
        if (wr)
            chk(mem_wdata_o & m, e);
        else begin
            repeat (3) if (load_valid_o !== 1'b1) begin
                @(posedge sys_clk_i);
                #1;
            end
            chk(load_data_o, r);
        end
    endtask
    task automatic burst(input int cnt);
        logic [31:0] v;
        cses_size_t sz;
        repeat (cnt) begin
            v = rnd();
            sz = cses_size_t'(v[1:0]);
            access(v[2], sz, v[5:3] & (sz == CSES_SZ_BYTE ? 3'h7 : sz == CSES_SZ_HALF ? 3'h6 : 3'h4));
        end
    endtask
    task automatic prot_write(input logic exp);
        @(posedge sys_clk_i);
        protected_write_i <= 1'b1;
        @(posedge sys_clk_i);
        protected_write_i <= 1'b0;
        #1;
        chk(undef_exc_o, exp);
    endtask
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (4000) @(posedge sys_clk_i);
        failures++;
        close_out();
    end
    initial begin
        {reset_n_i, op_valid_i, debug_mode_i, big_endian_i, req_i, req_write_i, req_fetch_i} = '0;
        {req_multi_i, req_signed_i, desc_nonsecure_i, desc_second_level_i, nsf} = '0;
        {nonsecure_flag_wr_i, nonsecure_flag_val_i, protected_write_i, lock_request_i} = '0;
        {op_data_i, req_vaddr_i, saved_status_word_i, req_wdata_i, mem_rdata_i} = '0;
        op_i = CSES_OP_NONE;
        req_size_i = CSES_SZ_BYTE;
        st = CSES_ISA_WIDE;
        repeat (16) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        #1;
        chk(current_status_word_o, CSES_SW_RESET);
        chk({isa_state_o, nonsecure_flag_o, table_base_nonsecure_o}, {st, CSES_NS_RESET, 1'b0});
        do_op(CSES_OP_BRANCH_EXCHANGE, 32'h1, 1'b0);
        do_op(CSES_OP_MANAGED_ENTER, 32'h0, 1'b0);
        do_op(CSES_OP_BRANCH_EXCHANGE, 32'h0, 1'b0);
        do_op(CSES_OP_MANAGED_LEAVE, 32'h0, 1'b0);
        do_op(CSES_OP_BRANCH_LINK_EXCHANGE, 32'h0, 1'b0);
        do_op(CSES_OP_MANAGED_ENTER, 32'h0, 1'b0);
        do_op(CSES_OP_LOAD_PC, 32'h1, 1'b0);
        do_op(CSES_OP_BYTECODE_BRANCH, 32'h0, 1'b0);
        do_op(CSES_OP_STATUS_WRITE, CSES_SW_RESET, 1'b0);
        do_op(CSES_OP_EXC_ENTRY, 32'h0, 1'b0);
        do_op(CSES_OP_EXC_RETURN, 32'h010001f3, 1'b0);
        do_op(CSES_OP_STATUS_WRITE, CSES_SW_RESET, 1'b1);
        do_op(CSES_OP_STATUS_WRITE, 32'h010001f3, 1'b0);
        do_op(CSES_OP_EXC_RETURN, 32'h010001d3, 1'b0);
        do_op(CSES_OP_EXC_RETURN, CSES_SW_RESET, 1'b0);
        burst(48);
        access(1'b0, CSES_SZ_DOUBLE, 3'h2);
        access(1'b1, CSES_SZ_DOUBLE, 3'h6);
        access(1'b0, CSES_SZ_DOUBLE, 3'h4);
        access(1'b1, CSES_SZ_HALF, 3'h3);
        // second write with value 0 must not clear the flag
        @(posedge sys_clk_i);
        {nonsecure_flag_wr_i, nonsecure_flag_val_i} <= 2'h3;
        @(posedge sys_clk_i);
        nonsecure_flag_val_i <= 1'b0;
        @(posedge sys_clk_i);
        nonsecure_flag_wr_i <= 1'b0;
        nsf = 1'b1;
        @(posedge sys_clk_i);
        #1;
        chk({nonsecure_flag_o, table_base_nonsecure_o}, 2'h3);
        burst(24);
        prot_write(1'b0);
        @(posedge sys_clk_i);
        lock_request_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        prot_write(1'b1);
        close_out();
    end
endmodule

/* tb/cses_assertions.sv */
module cses_assertions
    import cses_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic req,
    input wire logic write,
    input wire logic [31:0] addr,
    input wire cses_pkg::cses_size_t size,
    input wire logic [7:0] lane_en,
    input wire logic rvalid,
    input wire logic write_lock
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // ---------------------------------------------------------------
    // lane enables follow size and low address bits
    // ---------------------------------------------------------------
    AST_BYTE_LANE: assert property (
        req && size == CSES_SZ_BYTE |-> lane_en == 8'h01 << addr[2:0])
        else $error("byte lane enables wrong");
    AST_HALF_LANE: assert property (
        req && size == CSES_SZ_HALF |-> lane_en == 8'h03 << addr[2:0])
        else $error("halfword lane enables wrong");
    AST_WORD_LANE: assert property (
        req && size == CSES_SZ_WORD |-> lane_en == (addr[2] ? 8'hf0 : 8'h0f))
        else $error("word lane enables wrong");
    AST_DOUBLE_LANE: assert property (
        req && size == CSES_SZ_DOUBLE |-> lane_en == 8'hff)
        else $error("doubleword lane enables wrong");
    AST_DOUBLE_ALIGN: assert property (
        req && size == CSES_SZ_DOUBLE |-> addr[1:0] == 2'h0)
        else $error("misaligned doubleword reached the bus");
    // ---------------------------------------------------------------
    // read answers and lock level
    // ---------------------------------------------------------------
    AST_READ_ANSWER: assert property (
        req && !write |=> rvalid)
        else $error("read not answered next cycle");
    AST_NO_STRAY_DATA: assert property (
        rvalid |-> $past(req && !write))
        else $error("read data without a read");
    AST_LOCK_LOW_RESET: assert property (
        $rose(reset_n_i) |-> !write_lock)
        else $error("lock high right after reset");
endmodule
